// *** design/ffm_consts.vh ***
`ifndef FFM_CONSTS_VH
`define FFM_CONSTS_VH

// ==========================================
// Register offsets
`define FFM_OFS_CONFIG    8'h15
`define FFM_OFS_SOURCE    8'h16
`define FFM_OFS_THRESHOLD 8'h17
`define FFM_OFS_COUNT     8'h18
`define FFM_OFS_INT_STAT  8'h19
`define FFM_OFS_INT_CLR   8'h1a
`define FFM_OFS_INT_EN    8'h1b

// ==========================================
// Config register fields
`define FFM_CFG_LATCH_BIT  7
`define FFM_CFG_COMB_BIT   6
`define FFM_CFG_ZEN_BIT    5
`define FFM_CFG_YEN_BIT    4
`define FFM_CFG_XEN_BIT    3
`define FFM_CFG_RST        5'h00

// ==========================================
// Source register fields
`define FFM_SRC_EA_BIT     7

// ==========================================
// Threshold and count register fields
`define FFM_THS_DBM_BIT    7
`define FFM_THS_RST        7'h00
`define FFM_DBM_RST        1'b1
`define FFM_CNT_RST        8'h00
`define FFM_CNT_MAX        8'hff

// ==========================================
// Interrupt status bits
`define FFM_IRQ_RISE_BIT   0
`define FFM_IRQ_FALL_BIT   1
`define FFM_IRQ_RST        2'h0

`endif

// *** design/ffm_axis_cmp.v ***
`timescale 1ns/1ps
`default_nettype none

module ffm_axis_cmp (
   input wire [7:0] sample,   // Two's complement axis sample
   input wire [6:0] ths,      // Unsigned threshold
   input wire motion,         // 1: above threshold, 0: at or below
   input wire en,             // Axis event enable
   output wire hit,           // Axis condition met
   output wire neg            // Sample is negative
);
   wire [7:0] mag;
   assign mag = sample[7] ? (~sample + 8'h01) : sample;
   assign neg = sample[7];
   assign hit = en & (motion ? (mag > {1'b0, ths}) : (mag <= {1'b0, ths}));
endmodule

`default_nettype wire

// *** design/ffm_event_detect.v ***
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ffm_consts.vh"

module ffm_event_detect (
   input wire clk_sys,           // System clock, 50 MHz
   input wire nrst,              // Synchronous reset, active low
   input wire [7:0] addr,        // Register address
   input wire [7:0] wdata,       // Register write data
   input wire wr,                // Write strobe
   input wire rd,                // Read strobe
   output reg [7:0] rdata,       // Read data, cycle after rd
   input wire sample_valid,      // New output data sample pulse
   input wire [7:0] x_sample,    // X axis sample
   input wire [7:0] y_sample,    // Y axis sample
   input wire [7:0] z_sample,    // Z axis sample
   output wire event_active,     // Event-active flag
   output wire irq               // Level interrupt
);
   // ==========================================
   // Registers
   reg event_latch_enable_q;
   reg combine_select_q;
   reg z_event_enable_q;
   reg y_event_enable_q;
   reg x_event_enable_q;
   reg [6:0] ffm_threshold_q;
   reg debounce_mode_q;
   reg [7:0] ffm_debounce_count_q;
   reg [7:0] cnt_q, cnt_d;
   reg ea_q, ea_d;
   reg [5:0] flags_q, flags_d;
   reg [1:0] int_stat_q;
   reg [1:0] int_en_q;

   wire hx, hy, hz, nx, ny, nz;
   wire any_en;
   wire cond;
   wire src_rd;
   wire lclr;
   wire [7:0] base_cnt;
   wire base_ea;
   wire [5:0] base_flags;
   wire [5:0] live_flags;
   wire [5:0] en_mask;
   wire [7:0] src_val;
   wire [1:0] int_set;
   wire [7:0] cnt_inc;

   // ==========================================
   // Axis comparators
   ffm_axis_cmp u_x (.sample(x_sample), .ths(ffm_threshold_q), .motion(combine_select_q),
      .en(x_event_enable_q), .hit(hx), .neg(nx));
   ffm_axis_cmp u_y (.sample(y_sample), .ths(ffm_threshold_q), .motion(combine_select_q),
      .en(y_event_enable_q), .hit(hy), .neg(ny));
   ffm_axis_cmp u_z (.sample(z_sample), .ths(ffm_threshold_q), .motion(combine_select_q),
      .en(z_event_enable_q), .hit(hz), .neg(nz));

   // block off with no axis enabled
   assign any_en = x_event_enable_q | y_event_enable_q | z_event_enable_q;

   assign cond = any_en & (combine_select_q ? (hx | hy | hz) :
      ((hx | ~x_event_enable_q) & (hy | ~y_event_enable_q) & (hz | ~z_event_enable_q)));

   assign live_flags = {hz, hz & nz, hy, hy & ny, hx, hx & nx};

   assign src_rd = rd && (addr == `FFM_OFS_SOURCE);
   assign lclr = event_latch_enable_q & src_rd;
   assign base_cnt = lclr ? `FFM_CNT_RST : cnt_q;
   assign base_ea = lclr ? 1'b0 : ea_q;
   assign base_flags = lclr ? 6'h00 : flags_q;
   assign cnt_inc = (base_cnt == `FFM_CNT_MAX) ? base_cnt : base_cnt + 8'h01;

   // ==========================================
   // Debounce and event flag
   // A sample arriving with the clearing read is applied after the clear, so it is not lost.
   always @* begin
      cnt_d = base_cnt;
      ea_d = base_ea;
      flags_d = base_flags;
      if (sample_valid) begin
         if (!any_en) begin
            cnt_d = `FFM_CNT_RST;
            ea_d = event_latch_enable_q & base_ea;
            flags_d = (event_latch_enable_q & base_ea) ? base_flags : 6'h00;
         end else if (event_latch_enable_q && base_ea) begin
            cnt_d = base_cnt;
         end else if (cond) begin
            cnt_d = cnt_inc;
            // A set flag stays set while the condition holds, even below the count
            ea_d = base_ea | (cnt_inc >= ffm_debounce_count_q);
            flags_d = live_flags;
         end else if (!debounce_mode_q) begin
            cnt_d = (base_cnt == 8'h00) ? 8'h00 : base_cnt - 8'h01;
            ea_d = base_ea & (cnt_d != 8'h00);
            flags_d = live_flags;
         end else begin
            cnt_d = `FFM_CNT_RST;
            ea_d = 1'b0;
            flags_d = live_flags;
         end
         if (event_latch_enable_q && base_ea)
            flags_d = base_flags;
      end
   end

   always @(posedge clk_sys) begin
      if (!nrst) begin
         cnt_q <= `FFM_CNT_RST;
         ea_q <= 1'b0;
         flags_q <= 6'h00;
      end else begin
         cnt_q <= cnt_d;
         ea_q <= ea_d;
         flags_q <= flags_d;
      end
   end

   assign event_active = ea_q;

   // ==========================================
   // Register writes
   // config, threshold, count and interrupt enable fields
   always @(posedge clk_sys) begin
      if (!nrst) begin
         event_latch_enable_q <= 1'b0;
         combine_select_q <= 1'b0;
         z_event_enable_q <= 1'b0;
         y_event_enable_q <= 1'b0;
         x_event_enable_q <= 1'b0;
         ffm_threshold_q <= `FFM_THS_RST;
         debounce_mode_q <= `FFM_DBM_RST;
         ffm_debounce_count_q <= `FFM_CNT_RST;
         int_en_q <= `FFM_IRQ_RST;
      end else if (wr) begin
         if (addr == `FFM_OFS_CONFIG) begin
            event_latch_enable_q <= wdata[`FFM_CFG_LATCH_BIT];
            combine_select_q <= wdata[`FFM_CFG_COMB_BIT];
            z_event_enable_q <= wdata[`FFM_CFG_ZEN_BIT];
            y_event_enable_q <= wdata[`FFM_CFG_YEN_BIT];
            x_event_enable_q <= wdata[`FFM_CFG_XEN_BIT];
         end else if (addr == `FFM_OFS_THRESHOLD) begin
            debounce_mode_q <= wdata[`FFM_THS_DBM_BIT];
            ffm_threshold_q <= wdata[6:0];
         end else if (addr == `FFM_OFS_COUNT) begin
            ffm_debounce_count_q <= wdata;
         end else if (addr == `FFM_OFS_INT_EN) begin
            int_en_q <= wdata[1:0];
         end
      end
   end

   // ==========================================
   // Interrupt status, set wins over clear
   assign int_set = {ea_q & ~ea_d, ea_d & ~ea_q};

   always @(posedge clk_sys) begin
      if (!nrst)
         int_stat_q <= `FFM_IRQ_RST;
      else if (wr && (addr == `FFM_OFS_INT_CLR))
         int_stat_q <= (int_stat_q & ~wdata[1:0]) | int_set;
      else
         int_stat_q <= int_stat_q | int_set;
   end

   assign irq = |(int_stat_q & int_en_q);

   // ==========================================
   // Register reads
   // disabled axes read zero
   assign en_mask = {{2{z_event_enable_q}}, {2{y_event_enable_q}}, {2{x_event_enable_q}}};
   assign src_val = {ea_q, 1'b0, flags_q & en_mask};

   always @(posedge clk_sys) begin
      if (!nrst)
         rdata <= 8'h00;
      else if (rd) begin
         if (addr == `FFM_OFS_CONFIG)
            rdata <= {event_latch_enable_q, combine_select_q, z_event_enable_q,
               y_event_enable_q, x_event_enable_q, 3'h0};
         else if (addr == `FFM_OFS_SOURCE)
            rdata <= src_val;
         else if (addr == `FFM_OFS_THRESHOLD)
            rdata <= {debounce_mode_q, ffm_threshold_q};
         else if (addr == `FFM_OFS_COUNT)
            rdata <= ffm_debounce_count_q;
         else if (addr == `FFM_OFS_INT_STAT)
            rdata <= {6'h00, int_stat_q};
         else if (addr == `FFM_OFS_INT_EN)
            rdata <= {6'h00, int_en_q};
         else
            rdata <= 8'h00;
      end else
         rdata <= 8'h00;
   end
endmodule

`default_nettype wire

// *** verif/ffm_event_detect_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ffm_consts.vh"

module ffm_event_detect_chk (
   input wire logic clk_sys,      // Clock
   input wire logic nrst,         // Sync reset
   input wire logic [7:0] addr,   // Address
   input wire logic [7:0] wdata,  // Write data
   input wire logic wr,           // Write strobe
   input wire logic rd,           // Read strobe
   input wire logic [7:0] rdata,  // Read data
   input wire logic sample_valid, // New sample
   input wire logic event_active  // Event flag
);
   logic [7:0] cfg_q;
   logic [5:0] off_m;
   logic src_rd;
   assign src_rd = rd && addr == `FFM_OFS_SOURCE;
   assign off_m = ~{{2{cfg_q[5]}}, {2{cfg_q[4]}}, {2{cfg_q[3]}}};
   // ==========================================
   // Config shadow: the ports alone cannot tell latch mode or enables
   always @(posedge clk_sys) begin
      if (!nrst)
         cfg_q <= 8'h00;
      else if (wr && addr == `FFM_OFS_CONFIG)
         cfg_q <= wdata;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==========================================
   // Properties
   ea_quiet_a: assert property (!sample_valid && !rd && !wr |=> $stable(event_active))
      else $error("event flag moved without a sample");
   src_ea_a: assert property (src_rd |=> rdata[7] == $past(event_active) && !rdata[6])
      else $error("source read shows wrong event flag");
   axis_off_a: assert property (src_rd |=> (rdata[5:0] & off_m) == 6'h00)
      else $error("disabled axis flag read nonzero");
   read_keep_a: assert property (src_rd && !cfg_q[7] && !sample_valid
      |=> $stable(event_active)) else $error("live mode read changed event flag");
   latch_clr_a: assert property (src_rd && cfg_q[7] && !sample_valid |=> !event_active)
      else $error("latched read left event flag set");
   latch_hold_a: assert property (cfg_q[7] && event_active && !rd && !wr
      |=> event_active) else $error("latched event flag dropped");
   block_off_a: assert property (cfg_q[5:3] == 3'b000 && !cfg_q[7] && sample_valid
      && !wr |=> !event_active) else $error("event with all axes disabled");
   cnt_back_a: assert property (wr && addr == `FFM_OFS_COUNT ##1 !wr ##1 rd
      && addr == `FFM_OFS_COUNT |=> rdata == $past(wdata, 3))
      else $error("count register readback wrong");
   cover property (src_rd && cfg_q[7] && event_active);
   cover property ($rose(event_active) && !cfg_q[7]);
   cover property (sample_valid && cfg_q[5:3] == 3'b000);
endmodule

bind ffm_event_detect ffm_event_detect_chk u_chk (.clk_sys, .nrst, .addr, .wdata, .wr, .rd,
   .rdata, .sample_valid, .event_active);
`default_nettype wire

// *** verif/ffm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ffm_host_model (
   input wire logic clk_sys,     // Clock
   input wire logic [7:0] rdata, // Read data
   output logic [7:0] addr,      // Address
   output logic [7:0] wdata,     // Write data
   output logic wr,              // Write strobe
   output logic rd               // Read strobe
);
   initial begin
      {addr, wdata, wr, rd} = 18'h00000;
   end
   // Data is inverted once released so a stale value never looks valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      wdata <= ~d;
      // One idle edge so a following call never drives the strobe in the same step
      @(posedge clk_sys);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// *** verif/tb_ffm_event_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ffm_consts.vh"

module tb_ffm_event_detect;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic sample_valid = 1'b0;
   logic [7:0] x_sample = 8'h00, y_sample = 8'h00, z_sample = 8'h00;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, event_active, irq;
   logic [7:0] cfg, got;
   logic [6:0] ths;
   logic [5:0] m_fl;
   logic [1:0] m_ist, ien;
   logic dbm, m_ea;
   int m_cnt, cnt_set, bad_count = 0, cmp_count = 0;

   ffm_event_detect u_dut (.clk_sys, .nrst, .addr, .wdata, .wr, .rd, .rdata, .sample_valid,
      .x_sample, .y_sample, .z_sample, .event_active, .irq);
   ffm_host_model u_host (.clk_sys, .rdata, .addr, .wdata, .wr, .rd);

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // ==========================================
   // Reference model
   function automatic logic hit(input logic [7:0] s);
      int m;
      m = s[7] ? 256 - s : s;
      return cfg[6] ? m > ths : m <= ths;
   endfunction
   task automatic set_ea(input logic v);
      m_ist = m_ist | {m_ea & !v, v & !m_ea};
      m_ea = v;
   endtask
   task automatic model(input logic [7:0] x, y, z);
      logic [2:0] h;
      h = cfg[5:3] & {hit(z), hit(y), hit(x)};
      if (!(cfg[7] && m_ea)) begin
         m_fl = {h[2], h[2] & z[7], h[1], h[1] & y[7], h[0], h[0] & x[7]};
         if (cfg[6] ? h != 0 : cfg[5:3] != 0 && (h | ~cfg[5:3]) == 3'b111) begin
            m_cnt++;
            set_ea(m_ea || m_cnt >= cnt_set);
         end else if (dbm || m_cnt <= 1) begin
            m_cnt = 0;
            set_ea(1'b0);
         end else
            m_cnt--;
      end
   endtask
   // ==========================================
   // Drivers and checks
   task automatic chk(input logic [7:0] g, e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic smp(input logic [7:0] x, y, z);
      x_sample <= x;
      y_sample <= y;
      z_sample <= z;
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      @(posedge clk_sys);
      model(x, y, z);
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      void'($urandom(86348));
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 16; k++) begin
         nrst <= 1'b0;
         @(posedge clk_sys);
         nrst <= 1'b1;
         {m_ea, m_fl, m_ist} = 9'h000;
         m_cnt = 0;
         u_host.rd_reg(`FFM_OFS_THRESHOLD, got);
         chk(got, 8'h80);
         u_host.rd_reg(8'h00, got);
         chk(got, 8'h00);
         cfg = {k[0], k[1], (k == 2) ? 3'b000 : 3'($urandom % 7 + 1), 3'b000};
         dbm = k[2];
         ths = 7'($urandom);
         cnt_set = k[3] ? 0 : $urandom % 4;
         ien = 2'($urandom);
         u_host.wr_reg(`FFM_OFS_CONFIG, cfg);
         u_host.wr_reg(`FFM_OFS_THRESHOLD, {dbm, ths});
         u_host.wr_reg(`FFM_OFS_INT_EN, {6'h00, ien});
         u_host.wr_reg(`FFM_OFS_COUNT, 8'(cnt_set));
         u_host.rd_reg(`FFM_OFS_COUNT, got);
         chk(got, 8'(cnt_set));
         for (int i = 0; i < 20; i++) begin
            // Threshold boundary and the most negative sample first
            if (i < 2)
               smp({1'b0, ths}, -{1'b0, ths}, 8'h80);
            else
               smp(8'($urandom), 8'($urandom), 8'($urandom));
            chk(event_active, m_ea);
            chk(irq, |(m_ist & ien));
            if ($urandom % 3 == 0) begin
               u_host.rd_reg(`FFM_OFS_SOURCE, got);
               chk(got, {m_ea, 1'b0, m_fl});
               if (cfg[7]) begin
                  m_cnt = 0;
                  m_fl = 6'h00;
                  set_ea(1'b0);
               end
            end
         end
         u_host.wr_reg(`FFM_OFS_INT_CLR, 8'h03);
         m_ist = 2'b00;
         @(posedge clk_sys);
         chk(irq, 1'b0);
         $display("test %0d done", k);
      end
      stop_test();
   end
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
